// [byte_fifo.sv]
`timescale 1ns/1ps
module byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic arst_n,
    // Filling side.
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Draining side.
    input wire logic out_ready,
    output logic out_valid,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wp_q;
    logic [AW:0] rp_q;

    wire full = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
    wire empty = (wp_q == rp_q);
    wire push = in_valid && !full;
    wire pop = out_ready && !empty;

    assign in_ready = !full;
    assign out_valid = !empty;
    assign out_data = mem[rp_q[AW-1:0]];

    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem[wp_q[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            wp_q <= '0;
            rp_q <= '0;
        end else begin
            wp_q <= push ? (AW+1)'(1) + wp_q : wp_q;
            rp_q <= pop ? (AW+1)'(1) + rp_q : rp_q;
        end
    end
endmodule

// [rtc_dev_model.sv]
`timescale 1ns/1ps
module rtc_dev_model (
    // Wire levels.
    input wire logic scl,
    input wire logic sda,
    // Open-drain pulls, high while pulling low.
    output logic scl_pull,
    output logic sda_pull,
    // Behaviour controls.
    input wire logic [7:0] dev_addr,
    input wire logic slow
);
    logic [7:0] mem [256];
    logic [7:0] ptr;
    logic [7:0] sh;
    logic act;
    logic first;
    logic have_ptr;
    logic rd;
    int n;
    int n_start;

    initial begin
        scl_pull = 1'b0;
        sda_pull = 1'b0;
        act = 1'b0;
        ptr = 8'h00;
        n_start = 0;
    end

    // ----------------------------------------------------------------
    // Framing.
    // ----------------------------------------------------------------
    always @(negedge sda) begin
        if (scl === 1'b1) begin
            act = 1'b1;
            first = 1'b1;
            have_ptr = 1'b0;
            rd = 1'b0;
            n = -1;
            sda_pull = 1'b0;
            n_start = n_start + 1;
        end
    end

    always @(posedge sda) begin
        if (scl === 1'b1) begin
            act = 1'b0;
            sda_pull = 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Bits and acknowledge.
    // ----------------------------------------------------------------
    always @(posedge scl) begin
        if (act && n >= 0 && n < 8 && !(rd && !first)) begin
            sh = {sh[6:0], sda};
        end else if (act && n == 8 && rd && !first && sda) begin
            act = 1'b0;
        end
    end

    always @(negedge scl) begin
        if (act) begin
            n = n + 1;
            if (n == 8 && !(rd && !first)) begin
                if (first && sh[7:1] != dev_addr[7:1]) begin
                    act = 1'b0;
                end else begin
                    if (first) begin
                        rd = sh[0];
                    end else if (!have_ptr) begin
                        ptr = sh;
                    end else begin
                        mem[ptr] = sh;
                        ptr = ptr + 8'h01;
                    end
                    have_ptr = have_ptr | !first;
                    sda_pull = 1'b1;
                end
            end else if (n == 8) begin
                sda_pull = 1'b0;
                ptr = ptr + 8'h01;
            end else if (n == 9) begin
                sda_pull = 1'b0;
                n = 0;
                first = 1'b0;
                if (rd) begin
                    sh = mem[ptr];
                    sda_pull = !sh[7];
                end
                if (slow) begin
                    scl_pull <= 1'b1;
                    scl_pull <= #400 1'b0;
                end
            end else if (rd && !first) begin
                sda_pull = !sh[7-n];
            end
        end
    end
endmodule

// [rtc_host_ctrl.sv]
`timescale 1ns/1ps
module rtc_host_ctrl #(
    parameter int DIV = rtc_host_pkg::QTR_CYC,
    parameter int FIFO_DEPTH = rtc_host_pkg::WFIFO_DEPTH
) (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic arst_n,
    // Command port.
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire rtc_host_pkg::cmd_s cmd,
    // Write data stream.
    input wire logic wr_valid,
    output logic wr_ready,
    input wire logic [7:0] wr_data,
    // Read data stream.
    output logic rd_valid,
    input wire logic rd_ready,
    output logic [7:0] rd_data,
    // Status.
    output logic busy,
    output rtc_host_pkg::evt_s evt,
    // Two-wire bus pins.
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe
);
    import rtc_host_pkg::*;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic scl_m_q, scl_s_q, sda_m_q, sda_s_q;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            scl_m_q <= 1'b1;
            scl_s_q <= 1'b1;
            sda_m_q <= 1'b1;
            sda_s_q <= 1'b1;
        end else begin
            scl_m_q <= scl_i;
            scl_s_q <= scl_m_q;
            sda_m_q <= sda_i;
            sda_s_q <= sda_m_q;
        end
    end

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    bus_state_e st_q;
    stage_e stg_q;
    cmd_s cmd_q;
    evt_s evt_q;
    logic [1:0] ph_q;
    logic [3:0] bit_q;
    logic [7:0] tx_q, rx_q, rem_q, ptr_q, rd_data_q;
    logic [11:0] div_q;
    logic restart_q, ack_q, abort_q, rd_valid_q, scl_oe_q, sda_oe_q;
    logic f_valid;
    logic [7:0] f_data;

    // ------------------------------------------------------------
    // Decoding
    // ------------------------------------------------------------
    wire run = (st_q == ST_START) || (st_q == ST_BIT) || (st_q == ST_STOP);
    wire tick = run && (div_q == 12'(DIV - 1));
    // The high phase is held until the line is seen high, so a slow rise is tolerated.
    wire adv = tick && !((ph_q == 2'd1) && !scl_s_q);
    wire rx_byte = (stg_q == STG_RDATA);
    wire last_byte = (rem_q == 8'd1);
    wire tx_bit = tx_q[3'd7 - bit_q[2:0]];                                  // [R8]
    wire ack_slot = (bit_q == ACK_SLOT);
    // Acknowledge read bytes except the last; release during transmitted acknowledge.
    wire bit_oe = ack_slot ? (rx_byte && !last_byte) : (!rx_byte && !tx_bit); // [R11] [R13]
    wire bus_free = scl_s_q && sda_s_q;                                      // [R1]
    wire fire = cmd_valid && cmd_ready;
    wire [7:0] first_reg = (cmd.rd && cmd.simple) ? ptr_q : cmd.ptr;
    wire refuse = (cmd.count == 8'd0) || hits_test(first_reg, cmd.count);   // [R16]
    wire byte_end = (st_q == ST_BIT) && adv && (ph_q == 2'd3) && ack_slot;
    wire wait_wr = (st_q == ST_WAIT) && (stg_q == STG_WDATA);
    wire wait_go = wait_wr ? f_valid : !rd_valid_q;

    logic scl_oe_d, sda_oe_d;

    // In bit slots the clock is low in phases 0 and 3, data changed only while it is low.
    always_comb begin
        case (st_q)
            ST_START: scl_oe_d = ((ph_q == 2'd0) && restart_q) || (ph_q == 2'd3);
            ST_BIT: scl_oe_d = (ph_q == 2'd0) || (ph_q == 2'd3);             // [R5] [R7]
            ST_WAIT: scl_oe_d = 1'b1;
            ST_STOP: scl_oe_d = (ph_q == 2'd0);
            default: scl_oe_d = 1'b0;
        endcase
    end

    always_comb begin
        case (st_q)
            ST_START: sda_oe_d = ph_q[1];                                   // [R2] [R4]
            ST_BIT: sda_oe_d = bit_oe;
            ST_STOP: sda_oe_d = !ph_q[1];                                   // [R3]
            default: sda_oe_d = 1'b0;                                       // [R12]
        endcase
    end

    assign cmd_ready = (st_q == ST_IDLE) && bus_free;
    assign busy = (st_q != ST_IDLE);
    assign scl_o = 1'b0;                                                    // [R17]
    assign sda_o = 1'b0;                                                    // [R17]
    assign scl_oe = scl_oe_q;
    assign sda_oe = sda_oe_q;
    assign rd_valid = rd_valid_q;
    assign rd_data = rd_data_q;
    assign evt = evt_q;

    // ------------------------------------------------------------
    // Write data buffer
    // ------------------------------------------------------------
    byte_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_wfifo (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .in_valid(wr_valid),
        .in_ready(wr_ready),
        .in_data(wr_data),
        .out_ready(wait_wr),
        .out_valid(f_valid),
        .out_data(f_data)
    );

    // ------------------------------------------------------------
    // Clock divider and pin registers
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            div_q <= '0;
            scl_oe_q <= 1'b0;
            sda_oe_q <= 1'b0;
        end else begin
            div_q <= (!run || tick) ? 12'd0 : div_q + 12'd1;
            scl_oe_q <= scl_oe_d;
            sda_oe_q <= sda_oe_d;
        end
    end

    // ------------------------------------------------------------
    // Transaction sequencer
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_q <= ST_IDLE;
            stg_q <= STG_ADDR_W;
            cmd_q <= '0;
            evt_q <= '0;
            ph_q <= 2'd0;
            bit_q <= 4'd0;
            tx_q <= 8'h00;
            rx_q <= 8'h00;
            rem_q <= 8'h00;
            ptr_q <= 8'h00;
            rd_data_q <= 8'h00;
            restart_q <= 1'b0;
            ack_q <= 1'b0;
            abort_q <= 1'b0;
            rd_valid_q <= 1'b0;
        end else begin
            evt_q <= '0;
            if (rd_valid_q && rd_ready) begin
                rd_valid_q <= 1'b0;
            end
            if (adv) begin
                ph_q <= ph_q + 2'd1;
            end
            if ((st_q == ST_BIT) && adv && (ph_q == 2'd2)) begin
                if (ack_slot) begin
                    ack_q <= !sda_s_q;
                end else begin
                    rx_q <= {rx_q[6:0], sda_s_q};                           // [R5] [R8]
                end
            end
            case (st_q)
                ST_IDLE: begin
                    if (fire && refuse) begin
                        evt_q.refused <= 1'b1;                              // [R16]
                    end else if (fire) begin
                        cmd_q <= cmd;
                        rem_q <= cmd.count;
                        st_q <= ST_START;
                        ph_q <= 2'd0;
                        restart_q <= 1'b0;
                        abort_q <= 1'b0;
                        if (cmd.rd && cmd.simple) begin
                            stg_q <= STG_ADDR_R;                            // [R19]
                            tx_q <= DEV_ADDR_R;                             // [R14] [R15]
                        end else begin
                            stg_q <= STG_ADDR_W;
                            tx_q <= DEV_ADDR_W;                             // [R14] [R15]
                        end
                    end
                end
                ST_START: begin
                    if (adv && (ph_q == 2'd3)) begin
                        st_q <= ST_BIT;
                        bit_q <= 4'd0;
                        restart_q <= 1'b0;
                    end
                end
                ST_BIT: begin
                    if (adv && (ph_q == 2'd3) && !ack_slot) begin
                        bit_q <= bit_q + 4'd1;                              // [R7]
                    end
                    if (byte_end) begin
                        bit_q <= 4'd0;
                        if (!rx_byte && !ack_q) begin
                            st_q <= ST_STOP;
                            abort_q <= 1'b1;
                            evt_q.nack <= 1'b1;
                        end else begin
                            case (stg_q)
                                STG_ADDR_W: begin
                                    stg_q <= STG_PTR;
                                    tx_q <= cmd_q.ptr;                      // [R18]
                                end
                                STG_PTR: begin
                                    ptr_q <= cmd_q.ptr;                     // [R18]
                                    if (cmd_q.rd) begin
                                        stg_q <= STG_ADDR_R;                // [R19]
                                        tx_q <= DEV_ADDR_R;
                                        st_q <= ST_START;
                                        restart_q <= 1'b1;                  // [R4]
                                    end else begin
                                        stg_q <= STG_WDATA;
                                        st_q <= ST_WAIT;
                                    end
                                end
                                STG_ADDR_R: begin
                                    stg_q <= STG_RDATA;
                                    st_q <= ST_WAIT;
                                end
                                STG_RDATA: begin
                                    rd_data_q <= rx_q;
                                    rd_valid_q <= 1'b1;
                                    ptr_q <= ptr_q + 8'd1;                  // [R10]
                                    rem_q <= rem_q - 8'd1;
                                    st_q <= last_byte ? ST_STOP : ST_WAIT;  // [R13]
                                end
                                default: begin
                                    ptr_q <= ptr_q + 8'd1;                  // [R10] [R18]
                                    rem_q <= rem_q - 8'd1;
                                    st_q <= last_byte ? ST_STOP : ST_WAIT;
                                end
                            endcase
                        end
                    end
                end
                ST_WAIT: begin
                    if (wait_go) begin
                        st_q <= ST_BIT;
                        ph_q <= 2'd0;
                        if (wait_wr) begin
                            tx_q <= f_data;
                        end
                    end
                end
                ST_STOP: begin
                    if (adv && (ph_q == 2'd3)) begin
                        st_q <= ST_IDLE;                                    // [R3]
                        evt_q.done <= !abort_q;
                    end
                end
                default: begin
                    st_q <= ST_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    property p_idle_released;
        @(posedge sys_clk) disable iff (!arst_n)
        (st_q == ST_IDLE) && ($past(st_q) == ST_IDLE) |-> !scl_oe_q && !sda_oe_q;
    endproperty
    a_idle_released: assert property (p_idle_released) else $error("bus held in idle"); // [R1]

    property p_start_cond;
        @(posedge sys_clk) disable iff (!arst_n)
        (st_q == ST_START) && (ph_q == 2'd2) && adv |=> sda_oe_q && !scl_oe_q ##1 scl_oe_q;
    endproperty
    a_start_cond: assert property (p_start_cond) else $error("bad start shape"); // [R2]

    property p_stop_cond;
        @(posedge sys_clk) disable iff (!arst_n)
        (st_q == ST_STOP) && (ph_q == 2'd1) && adv |=> sda_oe_q && !scl_oe_q ##1
            !sda_oe_q && !scl_oe_q;
    endproperty
    a_stop_cond: assert property (p_stop_cond) else $error("bad stop shape"); // [R3]

    property p_restart_addr;
        @(posedge sys_clk) disable iff (!arst_n)
        byte_end && (stg_q == STG_PTR) && cmd_q.rd && ack_q |=>
            (st_q == ST_START) && (tx_q == DEV_ADDR_R) && restart_q;
    endproperty
    a_restart_addr: assert property (p_restart_addr) else $error("no repeated start"); // [R4]

    property p_data_low_clk;
        @(posedge sys_clk) disable iff (!arst_n)
        $changed(sda_oe_q) && ($past(st_q, 2) == ST_BIT) && ($past(st_q) == ST_BIT)
            |-> scl_oe_q && $past(scl_oe_q);
    endproperty
    a_data_low_clk: assert property (p_data_low_clk) else $error("data moved, clock high"); // [R5]

    property p_msb_first;
        @(posedge sys_clk) disable iff (!arst_n)
        (st_q == ST_BIT) && !rx_byte && !ack_slot |=> sda_oe_q == !$past(tx_bit);
    endproperty
    a_msb_first: assert property (p_msb_first) else $error("wrong bit on the line"); // [R8]

    property p_ptr_step;
        @(posedge sys_clk) disable iff (!arst_n)
        byte_end && (stg_q == STG_RDATA) |=> ptr_q == $past(ptr_q) + 8'd1;
    endproperty
    a_ptr_step: assert property (p_ptr_step) else $error("pointer did not advance"); // [R10]

    property p_ack_release;
        @(posedge sys_clk) disable iff (!arst_n)
        (st_q == ST_BIT) && ack_slot && !rx_byte |=> !sda_oe_q;
    endproperty
    a_ack_release: assert property (p_ack_release) else $error("held data in ack slot"); // [R11]

    property p_ack_drop;
        @(posedge sys_clk) disable iff (!arst_n)
        byte_end && rx_byte && !last_byte |=> ##1 !sda_oe_q;
    endproperty
    a_ack_drop: assert property (p_ack_drop) else $error("ack not released"); // [R12]

    property p_last_nack;
        @(posedge sys_clk) disable iff (!arst_n)
        (st_q == ST_BIT) && ack_slot && rx_byte && last_byte |=> !sda_oe_q;
    endproperty
    a_last_nack: assert property (p_last_nack) else $error("last byte acknowledged"); // [R13]

    property p_first_addr;
        @(posedge sys_clk) disable iff (!arst_n)
        (st_q == ST_START) && adv && (ph_q == 2'd3) |=>
            (tx_q == DEV_ADDR_W) || (tx_q == DEV_ADDR_R);
    endproperty
    a_first_addr: assert property (p_first_addr) else $error("bad address byte"); // [R15]

    property p_no_test_reg;
        @(posedge sys_clk) disable iff (!arst_n)
        fire && hits_test(first_reg, cmd.count) |=> (st_q == ST_IDLE) && evt_q.refused;
    endproperty
    a_no_test_reg: assert property (p_no_test_reg) else $error("test register reached"); // [R16]

    c_write_done: cover property (@(posedge sys_clk) disable iff (!arst_n)
        evt_q.done && !cmd_q.rd);
    c_read_done: cover property (@(posedge sys_clk) disable iff (!arst_n)
        evt_q.done && cmd_q.rd && !cmd_q.simple);
    c_nack: cover property (@(posedge sys_clk) disable iff (!arst_n) evt_q.nack);
    c_restart: cover property (@(posedge sys_clk) disable iff (!arst_n)
        (st_q == ST_START) && restart_q);
endmodule

// [rtc_host_ctrl_tb_top.sv]
`timescale 1ns/1ps
`define CHK(got, exp) \
    begin \
        check_count++; \
        if ((got) !== (exp)) begin \
            n_mismatch++; \
            $display("[ERR] t=%0t got %h exp %h", $time, (got), (exp)); \
        end \
    end
module rtc_host_ctrl_tb_top;
    import rtc_host_pkg::*;
    logic sys_clk, arst_n, cmd_valid, cmd_ready, wr_valid, wr_ready, rd_valid, rd_ready, busy;
    logic scl_o, scl_oe, sda_o, sda_oe, scl_w, sda_w, m_scl, m_sda, slow;
    logic [7:0] wr_data, rd_data, dev_addr;
    cmd_s cmd;
    evt_s evt, e;
    int n_mismatch, check_count, n0;

    // ----------------------------------------------------------------
    // Open-drain wires with pull-ups.
    // ----------------------------------------------------------------
    assign scl_w = !(scl_oe || m_scl);
    assign sda_w = !(sda_oe || m_sda);

    rtc_host_ctrl #(.DIV(2), .FIFO_DEPTH(16)) u_rtc_host_ctrl (
        .sys_clk(sys_clk), .arst_n(arst_n), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
        .cmd(cmd), .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data),
        .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data), .busy(busy), .evt(evt),
        .scl_i(scl_w), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_w), .sda_o(sda_o),
        .sda_oe(sda_oe));
    rtc_dev_model u_rtc_dev_model (.scl(scl_w), .sda(sda_w), .scl_pull(m_scl),
        .sda_pull(m_sda), .dev_addr(dev_addr), .slow(slow));

    always #4 sys_clk = !sys_clk;

    // ----------------------------------------------------------------
    // Shared tasks.
    // ----------------------------------------------------------------
    task automatic send(input logic r, input logic s, input logic [7:0] p, input logic [7:0] c);
        for (int k = 0; k < 100 && cmd_ready !== 1'b1; k++) @(negedge sys_clk);
        @(posedge sys_clk);
        cmd_valid <= 1'b1;
        cmd <= {r, s, p, c};
        @(posedge sys_clk);
        cmd_valid <= 1'b0;
    endtask

    task automatic wait_evt();
        e = '0;
        for (int k = 0; k < 40000 && e === '0; k++) begin
            #1;
            e = evt;
            @(posedge sys_clk);
        end
    endtask

    // Holds the read stream back a while so that the bus has to wait.
    task automatic rd_take(input logic [7:0] exp);
        #1;
        for (int k = 0; k < 5000 && rd_valid !== 1'b1; k++) begin
            @(posedge sys_clk);
            #1;
        end
        repeat (6) @(posedge sys_clk);
        `CHK(rd_data, exp);
        rd_ready <= 1'b1;
        @(posedge sys_clk);
        rd_ready <= 1'b0;
    endtask

    task automatic test_done();
        $display("Comparisons %0d, mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Scenarios.
    // ----------------------------------------------------------------
    task automatic t_idle();
        `CHK({scl_w, sda_w}, 2'b11);
        `CHK({busy, cmd_ready}, 2'b01);
        `CHK({scl_o, sda_o}, 2'b00);
    endtask

    task automatic t_fifo_write();
        for (int i = 0; i < 17; i++) begin
            @(posedge sys_clk);
            wr_valid <= 1'b1;
            wr_data <= 8'(8'hc0 + i);
        end
        @(posedge sys_clk);
        wr_valid <= 1'b0;
        #1;
        `CHK(wr_ready, 1'b0);
        slow <= 1'b1;
        send(1'b0, 1'b0, 8'h00, 8'd16);
        wait_evt();
        slow <= 1'b0;
        `CHK(e, 3'b100);
        for (int i = 0; i < 16; i++) `CHK(u_rtc_dev_model.mem[i], 8'(8'hc0 + i));
        `CHK(u_rtc_dev_model.ptr, 8'h10);
        `CHK({wr_ready, scl_w, sda_w}, 3'b111);
    endtask

    task automatic t_reads();
        for (int i = 0; i < 5; i++) u_rtc_dev_model.mem[8'h20 + i] = 8'(8'h30 + i);
        n0 = u_rtc_dev_model.n_start;
        send(1'b1, 1'b0, 8'h20, 8'd3);
        for (int i = 0; i < 3; i++) rd_take(8'(8'h30 + i));
        wait_evt();
        `CHK(e, 3'b100);
        `CHK(u_rtc_dev_model.n_start - n0, 2);
        `CHK({u_rtc_dev_model.ptr, m_sda}, {8'h23, 1'b0});
        send(1'b1, 1'b1, 8'h00, 8'd2);
        rd_take(8'h33);
        rd_take(8'h34);
        wait_evt();
        `CHK(e, 3'b100);
        `CHK(u_rtc_dev_model.n_start - n0, 3);
    endtask

    task automatic t_refuse();
        logic [7:0] rp [3] = '{8'h48, 8'h4a, 8'h10};
        logic [7:0] rc [3] = '{8'd2, 8'd1, 8'd0};
        for (int i = 0; i < 3; i++) begin
            n0 = u_rtc_dev_model.n_start;
            send(1'b0, 1'b0, rp[i], rc[i]);
            wait_evt();
            `CHK(e, 3'b001);
            `CHK(u_rtc_dev_model.n_start - n0, 0);
        end
    endtask

    task automatic t_nack();
        dev_addr <= 8'ha0;
        send(1'b0, 1'b0, 8'h50, 8'd1);
        wait_evt();
        `CHK(e, 3'b010);
        for (int k = 0; k < 200 && busy === 1'b1; k++) @(posedge sys_clk);
        #1;
        `CHK({scl_w, sda_w, busy}, 3'b110);
    endtask

    initial begin
        sys_clk = 1'b0;
        arst_n = 1'b0;
        {cmd_valid, wr_valid, rd_ready, slow} = 4'h0;
        cmd = '0;
        wr_data = 8'h00;
        dev_addr = DEV_ADDR_W;
        n_mismatch = 0;
        check_count = 0;
        repeat (3) @(posedge sys_clk);
        arst_n <= 1'b1;
        @(posedge sys_clk);
        #1;
        t_idle();
        t_fifo_write();
        t_reads();
        t_refuse();
        t_nack();
        test_done();
    end

    initial begin
        #500000;
        n_mismatch++;
        test_done();
    end
endmodule

// [rtc_host_pkg.sv]
// Notes on behaviour
// [R1] Both lines are released while no transfer runs; commands wait for a free bus.
// [R2] Start is data falling while the clock is high.
// [R3] Stop is data rising while the clock is high; then idle.
// [R4] A repeated start behaves like a start and is followed by an address byte.
// [R5] Data changes only while the clock is low; sampling happens while it is high.
// [R6] The device treats data edges during clock high as start or stop.
// [R7] One bit per clock pulse; this controller makes every pulse.
// [R8] Transfers are whole bytes, most significant bit first.
// [R9] The device accepts any number of bytes between start and stop.
// [R10] The register pointer advances after every byte read or written.
// [R11] After the eighth bit the transmitter releases data; receiver acknowledges low.
// [R12] An acknowledging receiver releases data at the falling edge of the ninth clock.
// [R13] The last read byte is not acknowledged, then a stop follows.
// [R14] The first byte is a seven-bit address plus direction bit, one meaning read.
// [R15] Address bytes are d1 for read and d0 for write.
// [R16] Registers 49 and 4a are never accessed.
// [R17] Lines are only pulled low or released, never driven high.
// [R18] First written byte loads the pointer; later bytes are data with increments.
// [R19] Simplified read sends the read address; standard read writes pointer then restarts.
package rtc_host_pkg;

    localparam logic [7:0] DEV_ADDR_W = 8'hd0;
    localparam logic [7:0] DEV_ADDR_R = 8'hd1;
    localparam logic [7:0] TEST_REG_LO = 8'h49;
    localparam logic [7:0] TEST_REG_HI = 8'h4a;
    localparam logic [3:0] ACK_SLOT = 4'h8;

    localparam int CLK_PERIOD_NS = 8;
    localparam int SCL_PERIOD_NS = 2500;
    localparam int QTR_NS = SCL_PERIOD_NS / 4;
    localparam int QTR_CYC = (QTR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WFIFO_DEPTH = 16;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_START = 3'b001,
        ST_BIT = 3'b010,
        ST_WAIT = 3'b011,
        ST_STOP = 3'b100
    } bus_state_e;

    typedef enum logic [2:0] {
        STG_ADDR_W = 3'b000,
        STG_PTR = 3'b001,
        STG_WDATA = 3'b010,
        STG_ADDR_R = 3'b011,
        STG_RDATA = 3'b100
    } stage_e;

    typedef struct packed {
        logic rd;
        logic simple;
        logic [7:0] ptr;
        logic [7:0] count;
    } cmd_s;

    typedef struct packed {
        logic done;
        logic nack;
        logic refused;
    } evt_s;

    // True when a burst from start of the given length touches a test register.
    function automatic logic hits_test(input logic [7:0] start, input logic [7:0] count);
        logic [8:0] last;
        last = 9'({1'b0, start} + {1'b0, count} - 9'd1);
        return ((start <= TEST_REG_HI) && (last >= {1'b0, TEST_REG_LO})) ||
               (last >= (9'h100 + {1'b0, TEST_REG_LO}));
    endfunction

endpackage
